// ==== sfr_host.sv ====
// Host controller end: command sequencer with a read data FIFO
`timescale 1ns/1ns
module sfr_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output wire logic         in_ready,
	input  wire logic [W-1:0] in_data,
	output wire logic         out_valid,
	input  wire logic         out_ready,
	output wire logic [W-1:0] out_data
);

	localparam int AW = (D > 1) ? $clog2(D) : 1;

	if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
		$error("sfr_fifo depth must be a power of two, at least 2");
	end

	logic [W-1:0] mem_r [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic          push;
	logic          pop;

	assign in_ready  = (cnt_r != (AW+1)'(D));
	assign out_valid = (cnt_r != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem_r[rp_r];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_r + AW'(push);
			rp_r  <= rp_r + AW'(pop);
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule

////////////////////////////////////////////////////////////////////////////////

module sfr_host #(
	parameter int HALF = sfr_pkg::SCK_HALF_CYC
) (
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	sfr_link_if.hst          LINK,
	input  wire logic        CMD_VALID,
	output wire logic        CMD_READY,
	input  wire logic [7:0]  CMD_OP,
	input  wire logic [23:0] CMD_ADDR,
	input  wire logic [15:0] CMD_LEN,
	input  wire logic        TX_VALID,
	output wire logic        TX_READY,
	input  wire logic [7:0]  TX_DATA,
	output wire logic        RX_VALID,
	input  wire logic        RX_READY,
	output wire logic [7:0]  RX_DATA
);

	// Device needs sync plus edge detect plus register inside one half period
	if (HALF < 4 || HALF > 255) begin : g_chk
		$error("sfr_host HALF must be 4 to 255 system clocks");
	end

	typedef enum logic [4:0] {
		H_IDLE = 5'h01,
		H_LOW  = 5'h02,
		H_HIGH = 5'h04,
		H_GATE = 5'h08,
		H_END  = 5'h10
	} sfr_hst_e;

	sfr_hst_e    st_r;
	logic [7:0]  div_r;
	logic [6:0]  hcnt_r;
	logic [6:0]  nbits_r;
	logic [2:0]  bitc_r;
	logic [15:0] len_r;
	logic        in_hdr_r;
	logic        wr_r;
	logic        cs_n_r;
	logic        sck_r;
	logic [63:0] hdr_r;
	logic [7:0]  tx_sh_r;
	logic [7:0]  rx_sh_r;
	logic        push_r;
	logic        fifo_ready;
	logic        half_done;

	assign half_done = (div_r == 8'(HALF - 1));
	assign CMD_READY = (st_r == H_IDLE);
	assign TX_READY  = (st_r == H_GATE) && wr_r;

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			st_r     <= H_IDLE;
			div_r    <= 8'h00;
			hcnt_r   <= 7'h00;
			nbits_r  <= 7'h00;
			bitc_r   <= 3'h0;
			len_r    <= 16'h0000;
			in_hdr_r <= 1'b0;
			wr_r     <= 1'b0;
			cs_n_r   <= 1'b1;
			sck_r    <= 1'b0;
		end else begin
			case (st_r)
				H_IDLE: begin
					if (CMD_VALID) begin
						// Select falls, opcode leads the header
						cs_n_r   <= 1'b0;
						len_r    <= CMD_LEN;
						wr_r     <= (sfr_pkg::sfr_kind(CMD_OP) == sfr_pkg::K_BUFWR);
						nbits_r  <= 7'(sfr_pkg::OP_BITS + sfr_pkg::ADDR_BITS)
						            + {1'b0, sfr_pkg::sfr_dummy(CMD_OP)};
						hcnt_r   <= 7'h00;
						in_hdr_r <= 1'b1;
						div_r    <= 8'h00;
						st_r     <= H_LOW;
					end
				end
				H_LOW: begin
					div_r <= half_done ? 8'h00 : div_r + 8'h01;
					if (half_done) begin
						sck_r <= 1'b1;
						st_r  <= H_HIGH;
					end
				end
				H_HIGH: begin
					div_r <= half_done ? 8'h00 : div_r + 8'h01;
					if (half_done) begin
						sck_r <= 1'b0;
						if (in_hdr_r) begin
							if (hcnt_r == nbits_r - 7'h01) begin
								in_hdr_r <= 1'b0;
								st_r     <= (len_r == 16'h0000) ? H_END : H_GATE;
							end else begin
								hcnt_r <= hcnt_r + 7'h01;
								st_r   <= H_LOW;
							end
						end else if (bitc_r == 3'h7) begin
							len_r <= len_r - 16'h0001;
							st_r  <= (len_r == 16'h0001) ? H_END : H_GATE;
						end else begin
							bitc_r <= bitc_r + 3'h1;
							st_r   <= H_LOW;
						end
					end
				end
				H_GATE: begin
					// Stall the clock until data or FIFO space is there;
					// a push still in flight must land first or a full FIFO goes unseen
					if (wr_r ? TX_VALID : (fifo_ready && !push_r)) begin
						bitc_r <= 3'h0;
						st_r   <= H_LOW;
					end
				end
				H_END: begin
					// Select held low through the last data bit, released only here
					cs_n_r <= 1'b1;
					div_r  <= half_done ? 8'h00 : div_r + 8'h01;
					if (half_done) begin
						st_r <= H_IDLE;
					end
				end
				default: begin
					st_r <= H_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shift registers

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			hdr_r   <= 64'h0;
			tx_sh_r <= 8'h00;
			rx_sh_r <= 8'h00;
			push_r  <= 1'b0;
		end else begin
			push_r <= (st_r == H_HIGH) && half_done && !in_hdr_r && !wr_r && bitc_r == 3'h7;
			if (st_r == H_IDLE && CMD_VALID) begin
				hdr_r <= {CMD_OP, CMD_ADDR, 32'h0};
			end else if (st_r == H_HIGH && half_done && in_hdr_r) begin
				hdr_r <= {hdr_r[62:0], 1'b0};
			end
			if (st_r == H_GATE) begin
				tx_sh_r <= wr_r ? TX_DATA : 8'h00;
			end else if (st_r == H_HIGH && half_done && !in_hdr_r) begin
				tx_sh_r <= {tx_sh_r[6:0], 1'b0};
			end
			if (st_r == H_LOW && half_done && !in_hdr_r && !wr_r) begin
				rx_sh_r <= {rx_sh_r[6:0], LINK.so_line};
			end
		end
	end

	assign LINK.cs_n = cs_n_r;
	assign LINK.sck  = sck_r;
	assign LINK.si   = in_hdr_r ? hdr_r[63] : tx_sh_r[7];

	sfr_fifo #(
		.W (8),
		.D (4)
	) u_rx_fifo (
		.clk       (SYS_CLK),
		.rst       (RST),
		.in_valid  (push_r),
		.in_ready  (fifo_ready),
		.in_data   (rx_sh_r),
		.out_valid (RX_VALID),
		.out_ready (RX_READY),
		.out_data  (RX_DATA)
	);

endmodule

// ==== sfr_pkg.sv ====
// Shared opcodes, field layouts and timing constants of the serial flash read/buffer link
package sfr_pkg;

	localparam logic [7:0] OP_RD_FAST  = 8'h0b;
	localparam logic [7:0] OP_RD_SLOW  = 8'h03;
	localparam logic [7:0] OP_PG_RD    = 8'hd2;
	localparam logic [7:0] OP_B1_RD_HI = 8'hd4;
	localparam logic [7:0] OP_B1_RD_LO = 8'hd1;
	localparam logic [7:0] OP_B2_RD_HI = 8'hd6;
	localparam logic [7:0] OP_B2_RD_LO = 8'hd3;
	localparam logic [7:0] OP_B1_WR    = 8'h84;
	localparam logic [7:0] OP_B2_WR    = 8'h87;

	localparam int OP_BITS   = 8;
	localparam int ADDR_BITS = 24;
	localparam int PAGE_BITS = 12;
	localparam int BYTE_BITS = 9;
	localparam int HDR_BITS  = 64;

	localparam logic [5:0] DUMMY_FAST = 6'h08;
	localparam logic [5:0] DUMMY_PAGE = 6'h20;
	localparam logic [5:0] DUMMY_BUF  = 6'h08;
	localparam logic [5:0] DUMMY_NONE = 6'h00;

	localparam logic [8:0] LAST_BYTE_WIDE   = 9'h107;
	localparam logic [8:0] LAST_BYTE_NARROW = 9'h0ff;

	// Page number and offset positions in the 24-bit address
	localparam int WIDE_PAGE_LSB   = 9;
	localparam int NARROW_PAGE_LSB = 8;

	// Serial clock half period at the 50 MHz system clock
	localparam int SYS_PERIOD_NS = 20;
	localparam int SCK_HALF_NS   = 80;
	localparam int SCK_HALF_CYC  = (SCK_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

	typedef enum logic [2:0] {
		K_NONE  = 3'h0,
		K_CONT  = 3'h1,
		K_PAGE  = 3'h2,
		K_BUFRD = 3'h3,
		K_BUFWR = 3'h4
	} sfr_kind_e;

	function automatic sfr_kind_e sfr_kind(input logic [7:0] op);
		case (op)
			OP_RD_FAST, OP_RD_SLOW: sfr_kind = K_CONT;
			OP_PG_RD: sfr_kind = K_PAGE;
			OP_B1_RD_HI, OP_B1_RD_LO, OP_B2_RD_HI, OP_B2_RD_LO: sfr_kind = K_BUFRD;
			OP_B1_WR, OP_B2_WR: sfr_kind = K_BUFWR;
			default: sfr_kind = K_NONE;
		endcase
	endfunction

	function automatic logic [5:0] sfr_dummy(input logic [7:0] op);
		case (op)
			OP_RD_FAST: sfr_dummy = DUMMY_FAST;
			OP_PG_RD: sfr_dummy = DUMMY_PAGE;
			OP_B1_RD_HI, OP_B1_RD_LO, OP_B2_RD_HI, OP_B2_RD_LO: sfr_dummy = DUMMY_BUF;
			default: sfr_dummy = DUMMY_NONE;
		endcase
	endfunction

	function automatic logic sfr_second_buf(input logic [7:0] op);
		sfr_second_buf = (op == OP_B2_RD_HI) || (op == OP_B2_RD_LO) || (op == OP_B2_WR);
	endfunction

endpackage

// ==== sfr_link_if.sv ====
// Serial link between flash device end and host controller end
`timescale 1ns/1ns
interface sfr_link_if;
	logic cs_n;
	logic sck;
	logic si;
	logic so;
	logic so_oe;
	logic so_line;

	// Released output reads as a pulled-up line
	assign so_line = so_oe ? so : 1'b1;

	modport dev (
		input  cs_n,
		input  sck,
		input  si,
		output so,
		output so_oe
	);

	modport hst (
		output cs_n,
		output sck,
		output si,
		input  so_line
	);
endinterface

// ==== sfr_dev.sv ====
// Flash device end: command decode, array/buffer reads and buffer writes over the serial link
`timescale 1ns/1ns
module sfr_dev (
	input  wire logic                           SYS_CLK,
	input  wire logic                           RST,
	sfr_link_if.dev                             LINK,
	input  wire logic                           PAGE_256,
	output wire logic [sfr_pkg::PAGE_BITS-1:0]  ARR_PAGE,
	output wire logic [sfr_pkg::BYTE_BITS-1:0]  ARR_BYTE,
	input  wire logic [7:0]                     ARR_DATA,
	output wire logic                           BUF_SEL,
	output wire logic [sfr_pkg::BYTE_BITS-1:0]  BUF_ADDR,
	output wire logic                           BUF_WE,
	output wire logic [7:0]                     BUF_WDATA,
	input  wire logic [7:0]                     BUF_RDATA
);

	typedef enum logic [5:0] {
		D_OP    = 6'h01,
		D_ADDR  = 6'h02,
		D_DUMMY = 6'h04,
		D_RD    = 6'h08,
		D_WR    = 6'h10,
		D_IGN   = 6'h20
	} sfr_dst_e;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic sck_s1_r;
	logic sck_s2_r;
	logic sck_d_r;
	logic cs_s1_r;
	logic cs_s2_r;
	logic si_s1_r;
	logic si_s2_r;

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			sck_s1_r <= 1'b0;
			sck_s2_r <= 1'b0;
			sck_d_r  <= 1'b0;
			cs_s1_r  <= 1'b1;
			cs_s2_r  <= 1'b1;
			si_s1_r  <= 1'b0;
			si_s2_r  <= 1'b0;
		end else begin
			sck_s1_r <= LINK.sck;
			sck_s2_r <= sck_s1_r;
			sck_d_r  <= sck_s2_r;
			cs_s1_r  <= LINK.cs_n;
			cs_s2_r  <= cs_s1_r;
			si_s1_r  <= LINK.si;
			si_s2_r  <= si_s1_r;
		end
	end

	logic sck_rise;
	logic sck_fall;

	// Edges only count while selected, so clock idle level does not matter
	assign sck_rise = ~cs_s2_r & sck_s2_r & ~sck_d_r;
	assign sck_fall = ~cs_s2_r & ~sck_s2_r & sck_d_r;

	////////////////////////////////////////////////////////////////////////////////
	// Command sequencing

	sfr_dst_e            st_r;
	logic [5:0]          cnt_r;
	logic [23:0]         in_sh_r;
	logic [23:0]         bits_in;
	logic [7:0]          op_r;
	sfr_pkg::sfr_kind_e  kind_r;
	logic                buf2_r;
	logic [5:0]          dummy;
	sfr_pkg::sfr_kind_e  kind_dec;

	assign bits_in  = {in_sh_r[22:0], si_s2_r};
	assign kind_dec = sfr_pkg::sfr_kind(bits_in[7:0]);
	assign dummy    = sfr_pkg::sfr_dummy(op_r);

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			in_sh_r <= 24'h000000;
		end else if (sck_rise) begin
			in_sh_r <= bits_in;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			st_r   <= D_OP;
			cnt_r  <= 6'h00;
			op_r   <= 8'h00;
			kind_r <= sfr_pkg::K_NONE;
			buf2_r <= 1'b0;
		end else if (cs_s2_r) begin
			// Deselect aborts any command and rearms opcode capture
			st_r  <= D_OP;
			cnt_r <= 6'h00;
		end else if (sck_rise) begin
			case (st_r)
				D_OP: begin
					if (cnt_r == 6'(sfr_pkg::OP_BITS - 1)) begin
						op_r   <= bits_in[7:0];
						kind_r <= kind_dec;
						buf2_r <= sfr_pkg::sfr_second_buf(bits_in[7:0]);
						cnt_r  <= 6'h00;
						// Unknown opcodes are left to other logic; this end stays quiet
						st_r   <= (kind_dec == sfr_pkg::K_NONE) ? D_IGN : D_ADDR;
					end else begin
						cnt_r <= cnt_r + 6'h01;
					end
				end
				D_ADDR: begin
					if (cnt_r == 6'(sfr_pkg::ADDR_BITS - 1)) begin
						cnt_r <= 6'h00;
						if (dummy != sfr_pkg::DUMMY_NONE) begin
							st_r <= D_DUMMY;
						end else if (kind_r == sfr_pkg::K_BUFWR) begin
							st_r <= D_WR;
						end else begin
							st_r <= D_RD;
						end
					end else begin
						cnt_r <= cnt_r + 6'h01;
					end
				end
				D_DUMMY: begin
					if (cnt_r == dummy - 6'h01) begin
						cnt_r <= 6'h00;
						st_r  <= D_RD;
					end else begin
						cnt_r <= cnt_r + 6'h01;
					end
				end
				D_WR: begin
					// Write continues until deselect
					cnt_r <= (cnt_r == 6'h07) ? 6'h00 : cnt_r + 6'h01;
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Address pointer

	logic [sfr_pkg::PAGE_BITS-1:0] page_r;
	logic [sfr_pkg::BYTE_BITS-1:0] byte_r;
	logic [sfr_pkg::PAGE_BITS-1:0] page_nxt;
	logic [sfr_pkg::BYTE_BITS-1:0] byte_nxt;
	logic [sfr_pkg::PAGE_BITS-1:0] page_load;
	logic [sfr_pkg::BYTE_BITS-1:0] byte_load;
	logic [sfr_pkg::BYTE_BITS-1:0] byte_last;
	logic                          at_last;
	logic                          out_load;
	logic                          we_r;

	// Offset field also serves as buffer address; upper bits are don't care
	assign page_load = PAGE_256 ? bits_in[sfr_pkg::NARROW_PAGE_LSB +: sfr_pkg::PAGE_BITS]
	                            : bits_in[sfr_pkg::WIDE_PAGE_LSB +: sfr_pkg::PAGE_BITS];
	assign byte_load = PAGE_256 ? {1'b0, bits_in[7:0]} : bits_in[8:0];
	assign byte_last = PAGE_256 ? sfr_pkg::LAST_BYTE_NARROW : sfr_pkg::LAST_BYTE_WIDE;
	assign at_last   = (byte_r == byte_last);
	assign byte_nxt  = at_last ? '0 : byte_r + 9'h001;
	// Only continuous reads step the page; the counter rolls over at the array end
	assign page_nxt  = (at_last && kind_r == sfr_pkg::K_CONT) ? page_r + 12'h001 : page_r;

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			page_r <= '0;
			byte_r <= '0;
		end else if (sck_rise && st_r == D_ADDR && cnt_r == 6'(sfr_pkg::ADDR_BITS - 1)) begin
			page_r <= page_load;
			byte_r <= byte_load;
		end else if (out_load || we_r) begin
			page_r <= page_nxt;
			byte_r <= byte_nxt;
		end
	end

	assign ARR_PAGE = page_r;
	assign ARR_BYTE = byte_r;
	assign BUF_ADDR = byte_r;
	assign BUF_SEL  = buf2_r;

	////////////////////////////////////////////////////////////////////////////////
	// Read data out

	logic [2:0] ocnt_r;
	logic [6:0] osh_r;
	logic       so_r;
	logic [7:0] rdata;

	// Byte fetched at the fall that starts it, so boundaries cost no clocks
	assign out_load = sck_fall && st_r == D_RD && ocnt_r == 3'h0;
	// Array reads never select the buffer path
	assign rdata = (kind_r == sfr_pkg::K_BUFRD) ? BUF_RDATA : ARR_DATA;

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ocnt_r <= 3'h0;
			osh_r  <= 7'h00;
			so_r   <= 1'b0;
		end else if (cs_s2_r) begin
			ocnt_r <= 3'h0;
		end else if (sck_fall && st_r == D_RD) begin
			ocnt_r <= ocnt_r + 3'h1;
			if (ocnt_r == 3'h0) begin
				so_r  <= rdata[7];
				osh_r <= rdata[6:0];
			end else begin
				so_r  <= osh_r[6];
				osh_r <= {osh_r[5:0], 1'b0};
			end
		end
	end

	// Output enabled only in data phase; drops three system clocks after select rises, once the synchronised select is seen
	assign LINK.so    = so_r;
	assign LINK.so_oe = (st_r == D_RD);

	////////////////////////////////////////////////////////////////////////////////
	// Buffer write

	logic [7:0] wdata_r;

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			we_r    <= 1'b0;
			wdata_r <= 8'h00;
		end else begin
			// Write strobe exists only in the buffer write state
			we_r <= sck_rise && st_r == D_WR && cnt_r == 6'h07;
			if (sck_rise && st_r == D_WR && cnt_r == 6'h07) begin
				wdata_r <= bits_in[7:0];
			end
		end
	end

	assign BUF_WE    = we_r;
	assign BUF_WDATA = wdata_r;

endmodule

// ==== sfr_link_monitor.sv ====
// Concurrent checks on the serial link between the device end and the host end
`timescale 1ns/1ns
module sfr_link_monitor (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe,
	input wire logic so_line
);
	logic       sck_d_r;
	logic [7:0] rise_cnt_r;
	logic [7:0] op_r;
	logic [7:0] need;

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST)
			sck_d_r <= 1'b0;
		else
			sck_d_r <= sck;
	end

	// Saturates so a long stream cannot fold back to a small count
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST)
			rise_cnt_r <= 8'h00;
		else if (cs_n)
			rise_cnt_r <= 8'h00;
		else if (sck && !sck_d_r && rise_cnt_r != 8'hff)
			rise_cnt_r <= rise_cnt_r + 8'h01;
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST)
			op_r <= 8'h00;
		else if (sck && !sck_d_r && !cs_n && rise_cnt_r < 8'h08)
			op_r <= {op_r[6:0], si};
	end

	// Header bits before read data; zero for commands that never drive
	always_comb begin
		case (op_r)
			sfr_pkg::OP_RD_SLOW: need = 8'h20;
			sfr_pkg::OP_PG_RD: need = 8'h40;
			sfr_pkg::OP_RD_FAST, sfr_pkg::OP_B1_RD_HI, sfr_pkg::OP_B1_RD_LO,
			sfr_pkg::OP_B2_RD_HI, sfr_pkg::OP_B2_RD_LO: need = 8'h28;
			default: need = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////

	a_release_on_deselect: assert property (cs_n [*5] |-> !so_oe)
		else $error("output still driven after deselect");
	a_idle_pulled_up: assert property (!so_oe |-> so_line)
		else $error("released output line not high");
	a_drop_after_deselect: assert property ($fell(so_oe) |-> cs_n)
		else $error("output released while still selected");
	a_sck_when_selected: assert property ($rose(sck) |-> !cs_n)
		else $error("clock pulse while deselected");
	a_si_moves_low: assert property (!cs_n && $changed(si) |-> !sck)
		else $error("input data changed while clock high");
	a_so_moves_low: assert property (so_oe && $past(so_oe) && $changed(so) |-> !sck)
		else $error("output data changed while clock high");
	a_sck_high_min: assert property ($rose(sck) |-> sck [*4])
		else $error("clock high phase too short");
	a_sck_low_min: assert property ($fell(sck) |-> !sck [*4])
		else $error("clock low phase too short");
	a_out_start_count: assert property ($rose(so_oe) |-> rise_cnt_r == need)
		else $error("read data started after wrong header length");
	a_out_read_only: assert property (so_oe && !cs_n |-> need != 8'h00)
		else $error("output driven for a non-read command");

	c_read_start: cover property ($rose(so_oe));
	c_page_read: cover property (so_oe && need == 8'h40);
	c_cmd_end: cover property ($rose(cs_n));
endmodule

// ==== tb_top.sv ====
// Self-checking bench: device end and host end joined across the link
`timescale 1ns/1ns
module tb_top;
	typedef struct {
		logic [7:0]  op;
		logic [23:0] ad;
		int          len;
		logic        p256;
	} sfr_row_s;

	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        page_256 = 1'b0;
	logic [11:0] arr_page;
	logic [8:0]  arr_byte;
	logic [7:0]  arr_data;
	logic        buf_sel;
	logic [8:0]  buf_addr;
	logic        buf_we;
	logic [7:0]  buf_wdata;
	logic [7:0]  buf_rdata;
	logic        cmd_valid = 1'b0;
	logic        cmd_ready;
	logic [7:0]  cmd_op = 8'h00;
	logic [23:0] cmd_addr = 24'h000000;
	logic [15:0] cmd_len = 16'h0000;
	logic        tx_valid = 1'b0;
	logic        tx_ready;
	logic [7:0]  tx_data = 8'h00;
	logic        rx_valid;
	logic        rx_ready = 1'b0;
	logic [7:0]  rx_data;
	logic [7:0]  bm1 [512];
	logic [7:0]  bm2 [512];
	logic [7:0]  sh1 [512];
	logic [7:0]  sh2 [512];
	int          n_fail = 0;
	int          check_count = 0;
	int          we_cnt = 0;

	sfr_row_s rows [11] = '{
		'{sfr_pkg::OP_RD_FAST,  24'h000b04, 8, 1'b0},
		'{sfr_pkg::OP_RD_SLOW,  24'h0ffffe, 4, 1'b1},
		'{sfr_pkg::OP_PG_RD,    24'h000f05, 5, 1'b0},
		'{sfr_pkg::OP_PG_RD,    24'h0009fd, 5, 1'b1},
		'{sfr_pkg::OP_B1_WR,    24'h000106, 4, 1'b0},
		'{sfr_pkg::OP_B2_WR,    24'h0000fe, 4, 1'b1},
		'{sfr_pkg::OP_B1_RD_HI, 24'hfffd05, 5, 1'b0},
		'{sfr_pkg::OP_B1_RD_LO, 24'h000000, 2, 1'b0},
		'{sfr_pkg::OP_B2_RD_HI, 24'hab12fd, 5, 1'b1},
		'{sfr_pkg::OP_B2_RD_LO, 24'h000000, 2, 1'b1},
		'{8'h00,                24'h000000, 2, 1'b0}
	};

	always #10 sys_clk = ~sys_clk;

	sfr_link_if u_sfr_link_if ();

	sfr_dev u_sfr_dev (.SYS_CLK(sys_clk), .RST(rst), .LINK(u_sfr_link_if.dev),
		.PAGE_256(page_256), .ARR_PAGE(arr_page), .ARR_BYTE(arr_byte), .ARR_DATA(arr_data),
		.BUF_SEL(buf_sel), .BUF_ADDR(buf_addr), .BUF_WE(buf_we), .BUF_WDATA(buf_wdata),
		.BUF_RDATA(buf_rdata));

	sfr_host u_sfr_host (.SYS_CLK(sys_clk), .RST(rst), .LINK(u_sfr_link_if.hst),
		.CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op), .CMD_ADDR(cmd_addr),
		.CMD_LEN(cmd_len), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data),
		.RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_DATA(rx_data));

	sfr_link_monitor u_sfr_link_monitor (.SYS_CLK(sys_clk), .RST(rst),
		.cs_n(u_sfr_link_if.cs_n), .sck(u_sfr_link_if.sck), .si(u_sfr_link_if.si),
		.so(u_sfr_link_if.so), .so_oe(u_sfr_link_if.so_oe), .so_line(u_sfr_link_if.so_line));

	////////////////////////////////////////////////////////////////////////////////

	// Pattern mixes page and offset so a wrong page or byte step shows up
	function automatic logic [7:0] arr_val(input logic [11:0] pg, input logic [8:0] by);
		return pg[7:0] ^ by[7:0] ^ {by[8], pg[11:8], 3'h5};
	endfunction

	assign arr_data = arr_val(arr_page, arr_byte);
	assign buf_rdata = buf_sel ? bm2[buf_addr] : bm1[buf_addr];

	always @(posedge sys_clk) begin
		if (buf_we) begin
			if (buf_sel)
				bm2[buf_addr] <= buf_wdata;
			else
				bm1[buf_addr] <= buf_wdata;
			we_cnt <= we_cnt + 1;
		end
	end

	function automatic logic [7:0] exp_rd(input sfr_row_s r, input int i);
		int sz;
		int pg;
		int by;
		sz = r.p256 ? 256 : 264;
		pg = r.p256 ? int'(r.ad[19:8]) : int'(r.ad[20:9]);
		by = (r.p256 ? int'(r.ad[7:0]) : int'(r.ad[8:0])) + i;
		if (r.op == sfr_pkg::OP_B1_RD_HI || r.op == sfr_pkg::OP_B1_RD_LO)
			return sh1[by % sz];
		if (r.op == sfr_pkg::OP_B2_RD_HI || r.op == sfr_pkg::OP_B2_RD_LO)
			return sh2[by % sz];
		if (r.op == sfr_pkg::OP_PG_RD)
			return arr_val(12'(pg), 9'(by % sz));
		if (r.op == sfr_pkg::OP_RD_FAST || r.op == sfr_pkg::OP_RD_SLOW)
			return arr_val(12'((pg + by / sz) % 4096), 9'(by % sz));
		return 8'hff;
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic idle_chk;
		@(negedge sys_clk);
		check({1'b0, u_sfr_link_if.cs_n, u_sfr_link_if.sck, u_sfr_link_if.so_oe, cmd_ready,
			rx_valid, tx_ready, buf_we}, 8'h48);
	endtask

	// Stall holds the reader off for that many cycles so the FIFO fills
	task automatic run_cmd(input sfr_row_s r, input int stall);
		int n;
		int t;
		int we0;
		int sz;
		int off;
		logic wr;
		n = 0;
		we0 = we_cnt;
		sz = r.p256 ? 256 : 264;
		off = r.p256 ? int'(r.ad[7:0]) : int'(r.ad[8:0]);
		wr = (r.op == sfr_pkg::OP_B1_WR) || (r.op == sfr_pkg::OP_B2_WR);
		@(posedge sys_clk);
		page_256 <= r.p256;
		cmd_valid <= 1'b1;
		cmd_op <= r.op;
		cmd_addr <= r.ad;
		cmd_len <= 16'(r.len);
		tx_valid <= wr;
		tx_data <= 8'h5a;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		for (t = 0; t < 20000; t++) begin
			@(posedge sys_clk);
			rx_ready <= (t >= stall);
			if (tx_valid && tx_ready) begin
				if (r.op == sfr_pkg::OP_B2_WR)
					sh2[(off + n) % sz] = tx_data;
				else
					sh1[(off + n) % sz] = tx_data;
				n++;
				tx_valid <= (n < r.len);
				tx_data <= 8'h5a ^ 8'(n * 37);
			end
			if (rx_valid && rx_ready) begin
				check(rx_data, exp_rd(r, n));
				n++;
			end
			if (n == r.len && t > 8 && cmd_ready === 1'b1)
				break;
		end
		check(8'(we_cnt - we0), wr ? 8'(r.len) : 8'h00);
		idle_chk();
		if (t == 20000) begin
			n_fail++;
			give_verdict();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////

	initial begin
		for (int k = 0; k < 512; k++) begin
			bm1[k] = 8'(k) ^ 8'h3c;
			bm2[k] = 8'(k) ^ 8'hc3;
			sh1[k] = bm1[k];
			sh2[k] = bm2[k];
		end
		repeat (19) @(posedge sys_clk);
		idle_chk();
		@(posedge sys_clk);
		rst <= 1'b0;
		foreach (rows[i])
			run_cmd(rows[i], 0);
		// Reader stalls long enough for the FIFO to fill and the link to pause
		run_cmd('{sfr_pkg::OP_RD_FAST, 24'h000b00, 12, 1'b0}, 1500);
		// Reset in the middle of a read must leave both ends idle
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_op <= sfr_pkg::OP_PG_RD;
		cmd_addr <= 24'h000000;
		cmd_len <= 16'h0008;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		repeat (700) @(posedge sys_clk);
		rst <= 1'b1;
		idle_chk();
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		run_cmd(rows[0], 0);
		give_verdict();
	end
endmodule
